// ### core/dmac_pkg.sv
// Shared constants and types for the DMA channel and transfer controller.
// Assumes a single clock domain and an APB register port with 13-bit
// byte addresses and 32-bit data.
package dmac_pkg;

	// Structure sizes.
	localparam int NUM_DMA     = 32;
	localparam int NUM_QCH     = 8;
	localparam int NUM_Q       = 2;
	localparam int Q_DEPTH     = 16;
	localparam int NUM_REGIONS = 4;
	localparam int DST_DEPTH   = 4;
	localparam int DFIFO_BEATS = 16;
	localparam int BEAT_BYTES  = 8;

	// Register byte offsets.
	localparam logic [12:0] REG_EVT_STATUS = 13'h0000;
	localparam logic [12:0] REG_EVT_SET    = 13'h0004;
	localparam logic [12:0] REG_EVT_CLR    = 13'h0008;
	localparam logic [12:0] REG_EVT_ENABLE = 13'h000C;
	localparam logic [12:0] REG_QCH_STATUS = 13'h0010;
	localparam logic [12:0] REG_DMA_QMAP   = 13'h0014;
	localparam logic [12:0] REG_INT_ENABLE = 13'h0018;
	localparam logic [12:0] REG_INT_STATUS = 13'h001C;
	localparam logic [12:0] REG_ERR_STATUS = 13'h0020;
	localparam logic [12:0] REG_MISS_DMA   = 13'h0024;
	localparam logic [12:0] REG_MISS_QCH   = 13'h0028;
	localparam logic [12:0] REG_Q_THRESH   = 13'h002C;
	localparam logic [12:0] REG_Q_DEBUG    = 13'h0030;
	localparam logic [12:0] REG_CC_DEBUG   = 13'h0034;
	localparam logic [12:0] REG_TC_BURST   = 13'h0038;
	localparam logic [12:0] REG_QCH_MAP    = 13'h0040;
	localparam logic [12:0] REG_REGION     = 13'h0060;
	localparam logic [12:0] REG_PARAMETER_RAM_BASE = 13'h1000;

	// Error status bit positions.
	localparam int ERR_THRESH_Q0 = 0;
	localparam int ERR_NULL_SET  = 2;
	localparam int ERR_MISS_DMA  = 3;
	localparam int ERR_MISS_QCH  = 4;

	// Parameter set word indices and option word fields.
	localparam int W_OPT = 0;
	localparam int W_SRC = 1;
	localparam int W_CNT = 2;
	localparam int W_DST = 3;
	localparam int W_CCNT = 7;
	localparam int OPT_EARLY = 11;
	localparam int OPT_TCC_LSB = 12;
	localparam int OPT_INT_EN = 20;
	localparam int OPT_CHAIN_EN = 21;

	// Quick channel map fields.
	localparam int QM_WORD_LSB = 7;
	localparam int QM_QUEUE = 16;

	typedef enum logic [1:0] {
		SUB_IDLE = 2'b00,
		SUB_LOAD = 2'b01,
		SUB_SEND = 2'b11
	} dmac_sub_state_t;

	typedef struct packed {
		logic [31:0] src;
		logic [31:0] dst;
		logic [13:0] beats;
		logic [4:0]  tcc;
		logic        int_en;
		logic        chain_en;
		logic        early;
	} dmac_tr_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} dmac_rd_req_t;

	typedef struct packed {
		logic        valid;
		logic [63:0] data;
	} dmac_rd_ret_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [63:0] data;
	} dmac_wr_req_t;

endpackage : dmac_pkg

// ### core/dmac_top.sv
// Channel controller, event queues, submission logic and two transfer
// controllers with their read and write master ports.
// Assumes one clock; event pins are asynchronous, master ports are not.
// Notes on behaviour
// - Standard channel starts only on pin event, set-register write or chain.
// - Writing a quick channel's trigger word in its parameter set triggers it.
// - Every recognized trigger is recorded in an event status register at once.
// - Triggered channel is queued into its software-programmed queue.
// - Each event queue holds at most sixteen entries.
// - Triggers for a full queue stay pending and are queued later.
// - Simultaneous triggers: standard channels are queued before quick ones.
// - Within a group the lowest-numbered channel is queued first.
// - Each queue is served strictly first-in first-out.
// - Head entry causes its channel's parameter set to be read.
// - Only valid requests are sent, queue k to transfer controller k.
// - Controller reports completion after all data is written, if selected.
// - Optional early completion when the request leaves submission.
// - Completion chains another channel or sets a gated interrupt.
// - Missed events, queue threshold excess and null sets raise errors.
// - Interrupts are assigned to regions through per-region masks.
// - Debug registers show queue fill, active logic and missed events.
// - Controller sends a completion code when a non-early transfer with interrupt or chaining finishes.
// - Idle controller moves a request into active set and context FIFO.
// - While active, one further request is held in the program set.
// - Exhausted active set is reloaded from the program set.
// - Reads issue only with data FIFO room; count follows transfer size.
// - Writes start once the FIFO holds a full burst or the remainder.
// - Reads may run up to four requests ahead of writes.
// - All-zero counts are an error; partly zero gives a dummy transfer.
// - Read and write ports move eight bytes per beat.
// - Burst size per controller is selectable as 16, 32 or 64 bytes.
//
// The address map and the APB interface to the registers were decided locally.
module dmac_top (
	// Clock and reset.
	input  wire logic                  clk,
	input  wire logic                  reset,
	// APB register port.
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [12:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Peripheral event pins.
	input  wire logic [31:0]           evt_in,
	// Transfer controller master ports, one per controller.
	output dmac_pkg::dmac_rd_req_t [1:0] rd_req,
	input  wire logic [1:0]            rd_ready,
	input  dmac_pkg::dmac_rd_ret_t [1:0] rd_ret,
	output dmac_pkg::dmac_wr_req_t [1:0] wr_req,
	input  wire logic [1:0]            wr_ready,
	// Interrupt outputs.
	output logic [3:0]                 comp_irq,
	output logic                       err_irq
);

	logic [31:0] parameter_ram_ram [1024];
	logic [31:0] evt_pend_reg, evt_enable_reg, dma_qmap_reg, int_enable_reg;
	logic [31:0] int_status_reg, miss_dma_reg;
	logic [7:0]  qch_pend_reg, miss_qch_reg;
	logic [4:0]  err_status_reg;
	logic [16:0] qch_map_reg [8];
	logic [31:0] region_reg [4];
	logic [4:0]  q_thresh_reg [2];
	logic [3:0]  tc_burst_reg;
	logic [31:0] ev_s1_reg, ev_s2_reg, ev_s3_reg;
	logic [31:0] prdata_next;
	logic        pslverr_next;
	logic        wr_acc;
	logic [31:0] dma_trig, dma_taken, chain_set, int_set;
	logic [7:0]  qch_trig, qch_taken;
	logic [5:0]  q_mem [2][16];
	logic [3:0]  q_wp_reg [2];
	logic [3:0]  q_rp_reg [2];
	logic [4:0]  q_cnt_reg [2];
	logic [1:0]  enq_v, deq;
	logic [5:0]  enq_e [2];
	dmac_pkg::dmac_sub_state_t sub_state_reg;
	logic        sub_q_reg, rr_reg, pick_v, pick_q, null_set;
	logic [5:0]  sub_ent_reg;
	logic [6:0]  sub_set_reg;
	dmac_pkg::dmac_tr_t sub_tr_reg, load_tr;
	logic [1:0]  tr_push, tc_busy, tc_busy_prog;
	logic [2:0]  cmp_v, cmp_ie, cmp_ce;
	logic [4:0]  cmp_code [3];

	// Register writes land in the access cycle; pready never stretches.
	assign wr_acc = psel & penable & pwrite & pready;

	// APB answer is prepared in the setup cycle so it leaves a flip-flop.
	always_comb begin
		prdata_next = '0;
		pslverr_next = 1'b0;
		if (paddr[12]) begin
			prdata_next = parameter_ram_ram[paddr[11:2]];
		end else if (paddr[11:5] == dmac_pkg::REG_QCH_MAP[11:5]) begin
			prdata_next = {15'h0000, qch_map_reg[paddr[4:2]]};
		end else if (paddr[11:4] == dmac_pkg::REG_REGION[11:4]) begin
			prdata_next = region_reg[paddr[3:2]];
		end else begin
			unique case (paddr)
				dmac_pkg::REG_EVT_STATUS: prdata_next = evt_pend_reg;
				dmac_pkg::REG_EVT_SET:    prdata_next = '0;
				dmac_pkg::REG_EVT_CLR:    prdata_next = '0;
				dmac_pkg::REG_EVT_ENABLE: prdata_next = evt_enable_reg;
				dmac_pkg::REG_QCH_STATUS: prdata_next = {24'h000000, qch_pend_reg};
				dmac_pkg::REG_DMA_QMAP:   prdata_next = dma_qmap_reg;
				dmac_pkg::REG_INT_ENABLE: prdata_next = int_enable_reg;
				dmac_pkg::REG_INT_STATUS: prdata_next = int_status_reg;
				dmac_pkg::REG_ERR_STATUS: prdata_next = {27'h0000000, err_status_reg};
				dmac_pkg::REG_MISS_DMA:   prdata_next = miss_dma_reg;
				dmac_pkg::REG_MISS_QCH:   prdata_next = {24'h000000, miss_qch_reg};
				dmac_pkg::REG_Q_THRESH:   prdata_next = {19'h00000, q_thresh_reg[1],
					3'h0, q_thresh_reg[0]};
				dmac_pkg::REG_Q_DEBUG:    prdata_next = {19'h00000, q_cnt_reg[1],
					3'h0, q_cnt_reg[0]};
				dmac_pkg::REG_CC_DEBUG:   prdata_next = {27'h0000000, tc_busy,
					q_cnt_reg[1] != 5'h00, q_cnt_reg[0] != 5'h00,
					sub_state_reg != dmac_pkg::SUB_IDLE};
				dmac_pkg::REG_TC_BURST:   prdata_next = {28'h0000000, tc_burst_reg};
				default:                  pslverr_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prdata <= '0;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (psel & ~penable) begin
				prdata <= prdata_next;
				pslverr <= pslverr_next;
			end
		end
	end

	// Parameter RAM holds no control state, so it is left without reset.
	always_ff @(posedge clk) begin
		if (wr_acc & paddr[12])
			parameter_ram_ram[paddr[11:2]] <= pwdata;
	end

	// Software configuration registers.
	always_ff @(posedge clk) begin
		if (reset) begin
			evt_enable_reg <= '0;
			dma_qmap_reg <= '0;
			int_enable_reg <= '0;
			tc_burst_reg <= '0;
			for (int i = 0; i < dmac_pkg::NUM_QCH; i++)
				qch_map_reg[i] <= '0;
			for (int i = 0; i < dmac_pkg::NUM_REGIONS; i++)
				region_reg[i] <= '0;
			for (int i = 0; i < dmac_pkg::NUM_Q; i++)
				q_thresh_reg[i] <= 5'h10;
		end else if (wr_acc & ~paddr[12]) begin
			if (paddr[11:5] == dmac_pkg::REG_QCH_MAP[11:5])
				qch_map_reg[paddr[4:2]] <= pwdata[16:0];
			if (paddr[11:4] == dmac_pkg::REG_REGION[11:4])
				region_reg[paddr[3:2]] <= pwdata;
			if (paddr == dmac_pkg::REG_EVT_ENABLE)
				evt_enable_reg <= pwdata;
			if (paddr == dmac_pkg::REG_DMA_QMAP)
				dma_qmap_reg <= pwdata;
			if (paddr == dmac_pkg::REG_INT_ENABLE)
				int_enable_reg <= pwdata;
			if (paddr == dmac_pkg::REG_TC_BURST)
				tc_burst_reg <= pwdata[3:0];
			if (paddr == dmac_pkg::REG_Q_THRESH) begin
				q_thresh_reg[0] <= pwdata[4:0];
				q_thresh_reg[1] <= pwdata[12:8];
			end
		end
	end

	// Event pins pass two flip-flops; the third stage only feeds edge detect.
	always_ff @(posedge clk) begin
		if (reset) begin
			ev_s1_reg <= '0;
			ev_s2_reg <= '0;
			ev_s3_reg <= '0;
		end else begin
			ev_s1_reg <= evt_in;
			ev_s2_reg <= ev_s1_reg;
			ev_s3_reg <= ev_s2_reg;
		end
	end

	// Trigger sources for standard and quick channels.
	always_comb begin
		dma_trig = (ev_s2_reg & ~ev_s3_reg & evt_enable_reg) | chain_set;
		if (wr_acc && paddr == dmac_pkg::REG_EVT_SET)
			dma_trig = dma_trig | pwdata;
		for (int n = 0; n < dmac_pkg::NUM_QCH; n++)
			qch_trig[n] = wr_acc & paddr[12]
				& (paddr[11:5] == qch_map_reg[n][6:0])
				& (paddr[4:2] == qch_map_reg[n][9:7]);
	end

	// Pending triggers; a new trigger beats a clear in the same cycle.
	always_ff @(posedge clk) begin
		if (reset) begin
			evt_pend_reg <= '0;
			qch_pend_reg <= '0;
			miss_dma_reg <= '0;
			miss_qch_reg <= '0;
		end else begin
			evt_pend_reg <= (evt_pend_reg & ~dma_taken
				& ~((wr_acc && paddr == dmac_pkg::REG_EVT_CLR) ? pwdata : '0))
				| dma_trig;
			qch_pend_reg <= (qch_pend_reg & ~qch_taken) | qch_trig;
			miss_dma_reg <= (miss_dma_reg
				& ~((wr_acc && paddr == dmac_pkg::REG_MISS_DMA) ? pwdata : '0))
				| (dma_trig & evt_pend_reg & ~dma_taken);
			miss_qch_reg <= (miss_qch_reg
				& ~((wr_acc && paddr == dmac_pkg::REG_MISS_QCH) ? pwdata[7:0] : '0))
				| (qch_trig & qch_pend_reg & ~qch_taken);
		end
	end

	// Per-queue arbitration: scanning downward lets the lowest channel win,
	// and the standard scan runs last so it overrides any quick choice.
	always_comb begin
		dma_taken = '0;
		qch_taken = '0;
		for (int q = 0; q < dmac_pkg::NUM_Q; q++) begin
			enq_v[q] = 1'b0;
			enq_e[q] = '0;
			if (q_cnt_reg[q] < 5'(dmac_pkg::Q_DEPTH)) begin
				for (int n = dmac_pkg::NUM_QCH - 1; n >= 0; n--)
					if (qch_pend_reg[n] && qch_map_reg[n][dmac_pkg::QM_QUEUE] == 1'(q)) begin
						enq_v[q] = 1'b1;
						enq_e[q] = {3'b100, 3'(n)};
					end
				for (int c = dmac_pkg::NUM_DMA - 1; c >= 0; c--)
					if (evt_pend_reg[c] && dma_qmap_reg[c] == 1'(q)) begin
						enq_v[q] = 1'b1;
						enq_e[q] = {1'b0, 5'(c)};
					end
			end
			if (enq_v[q] && enq_e[q][5])
				qch_taken[enq_e[q][2:0]] = 1'b1;
			else if (enq_v[q])
				dma_taken[enq_e[q][4:0]] = 1'b1;
		end
	end

	// Event queue storage and occupancy.
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int q = 0; q < dmac_pkg::NUM_Q; q++) begin
				q_wp_reg[q] <= '0;
				q_rp_reg[q] <= '0;
				q_cnt_reg[q] <= '0;
			end
		end else begin
			for (int q = 0; q < dmac_pkg::NUM_Q; q++) begin
				if (enq_v[q]) begin
					q_mem[q][q_wp_reg[q]] <= enq_e[q];
					q_wp_reg[q] <= q_wp_reg[q] + 4'h1;
				end
				if (deq[q])
					q_rp_reg[q] <= q_rp_reg[q] + 4'h1;
				q_cnt_reg[q] <= q_cnt_reg[q] + 5'(enq_v[q]) - 5'(deq[q]);
			end
		end
	end

	// Submission picks queues alternately so neither controller starves.
	always_comb begin
		pick_v = (q_cnt_reg[0] != 5'h00) | (q_cnt_reg[1] != 5'h00);
		pick_q = (q_cnt_reg[rr_reg] != 5'h00) ? rr_reg : ~rr_reg;
		for (int q = 0; q < dmac_pkg::NUM_Q; q++) begin
			deq[q] = (sub_state_reg == dmac_pkg::SUB_IDLE) & pick_v & (pick_q == 1'(q));
			tr_push[q] = (sub_state_reg == dmac_pkg::SUB_SEND)
				& (sub_q_reg == 1'(q)) & ~tc_busy_prog[q];
		end
		load_tr.src = parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_SRC)}];
		load_tr.dst = parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_DST)}];
		load_tr.tcc = parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_OPT)}][dmac_pkg::OPT_TCC_LSB +: 5];
		load_tr.int_en = parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_OPT)}][dmac_pkg::OPT_INT_EN];
		load_tr.chain_en = parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_OPT)}][dmac_pkg::OPT_CHAIN_EN];
		load_tr.early = parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_OPT)}][dmac_pkg::OPT_EARLY];
		// One array per event, rounded up to whole eight-byte beats.
		load_tr.beats = 14'((17'(parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_CNT)}][15:0])
			+ 17'(dmac_pkg::BEAT_BYTES - 1)) >> 3);
		null_set = (parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_CNT)}] == 32'h00000000)
			& (parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_CCNT)}][15:0] == 16'h0000);
		if (parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_CNT)}][15:0] == 16'h0000
			|| parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_CNT)}][31:16] == 16'h0000
			|| parameter_ram_ram[{sub_set_reg, 3'(dmac_pkg::W_CCNT)}][15:0] == 16'h0000)
			load_tr.beats = '0;
	end

	// Submission sequence: pop head, read its set, check, hand over.
	always_ff @(posedge clk) begin
		if (reset) begin
			sub_state_reg <= dmac_pkg::SUB_IDLE;
			sub_q_reg <= 1'b0;
			rr_reg <= 1'b0;
			sub_ent_reg <= '0;
			sub_set_reg <= '0;
			sub_tr_reg <= '0;
		end else begin
			unique case (sub_state_reg)
				dmac_pkg::SUB_IDLE: if (pick_v) begin
					sub_q_reg <= pick_q;
					rr_reg <= ~pick_q;
					sub_ent_reg <= q_mem[pick_q][q_rp_reg[pick_q]];
					sub_set_reg <= q_mem[pick_q][q_rp_reg[pick_q]][5]
						? qch_map_reg[q_mem[pick_q][q_rp_reg[pick_q]][2:0]][6:0]
						: {2'b00, q_mem[pick_q][q_rp_reg[pick_q]][4:0]};
					sub_state_reg <= dmac_pkg::SUB_LOAD;
				end
				dmac_pkg::SUB_LOAD: begin
					sub_tr_reg <= load_tr;
					sub_state_reg <= null_set ? dmac_pkg::SUB_IDLE
						: dmac_pkg::SUB_SEND;
				end
				dmac_pkg::SUB_SEND: if (tr_push[sub_q_reg])
					sub_state_reg <= dmac_pkg::SUB_IDLE;
			endcase
		end
	end

	// Early completion is reported as the request leaves submission.
	assign cmp_v[2] = (|tr_push) & sub_tr_reg.early;
	assign cmp_code[2] = sub_tr_reg.tcc;
	assign cmp_ie[2] = sub_tr_reg.int_en;
	assign cmp_ce[2] = sub_tr_reg.chain_en;

	// Completion codes turn into chain triggers or interrupt status bits.
	always_comb begin
		int_set = '0;
		chain_set = '0;
		for (int s = 0; s < 3; s++) begin
			if (cmp_v[s] && cmp_ie[s])
				int_set[cmp_code[s]] = 1'b1;
			if (cmp_v[s] && cmp_ce[s])
				chain_set[cmp_code[s]] = 1'b1;
		end
	end

	// Status flags: hardware set wins over a software clear.
	always_ff @(posedge clk) begin
		if (reset) begin
			int_status_reg <= '0;
			err_status_reg <= '0;
			comp_irq <= '0;
			err_irq <= 1'b0;
		end else begin
			int_status_reg <= (int_status_reg
				& ~((wr_acc && paddr == dmac_pkg::REG_INT_STATUS) ? pwdata : '0))
				| int_set;
			err_status_reg <= (err_status_reg
				& ~((wr_acc && paddr == dmac_pkg::REG_ERR_STATUS) ? pwdata[4:0] : '0))
				| {|(qch_trig & qch_pend_reg & ~qch_taken),
				|(dma_trig & evt_pend_reg & ~dma_taken),
				sub_state_reg == dmac_pkg::SUB_LOAD && null_set,
				q_cnt_reg[1] > q_thresh_reg[1],
				q_cnt_reg[0] > q_thresh_reg[0]};
			for (int r = 0; r < dmac_pkg::NUM_REGIONS; r++)
				comp_irq[r] <= |(int_status_reg & int_enable_reg & region_reg[r]);
			err_irq <= |err_status_reg;
		end
	end

	// Two transfer controllers, each fed by its own queue.
	for (genvar t = 0; t < dmac_pkg::NUM_Q; t++) begin : g_tc
		dmac_pkg::dmac_tr_t prog_tr_reg, head;
		dmac_pkg::dmac_tr_t dctx [dmac_pkg::DST_DEPTH];
		dmac_pkg::dmac_rd_req_t rd_q_reg;
		dmac_pkg::dmac_wr_req_t wr_q_reg;
		logic [63:0] dmem [dmac_pkg::DFIFO_BEATS];
		logic        prog_v_reg, cmp_v_reg, move, rd_fire, wr_fire;
		logic        rd_issue, wr_issue, burst_start, retire;
		logic [13:0] rd_left_reg, wr_done_reg, wr_left;
		logic [31:0] rd_addr_reg;
		logic [1:0]  dwp_reg, drp_reg;
		logic [2:0]  dcnt_reg;
		logic [3:0]  fwp_reg, frp_reg, burst_left_reg, burst_beats, burst_len;
		logic [4:0]  fcnt_reg, outst_reg, cmp_code_reg;
		logic [5:0]  f_used;
		logic        cmp_ie_reg, cmp_ce_reg;

		assign head = dctx[drp_reg];
		assign wr_left = head.beats - wr_done_reg;
		assign rd_fire = rd_q_reg.valid & rd_ready[t];
		assign wr_fire = wr_q_reg.valid & wr_ready[t];
		// Move from program set once the active set is exhausted.
		assign move = prog_v_reg & (rd_left_reg == 14'h0000)
			& (dcnt_reg < 3'(dmac_pkg::DST_DEPTH));
		// Room counts stored beats, reads in flight and the held request.
		assign f_used = 6'(fcnt_reg) + 6'(outst_reg) + 6'(rd_q_reg.valid);
		assign rd_issue = (rd_left_reg != 14'h0000) & (~rd_q_reg.valid | rd_fire)
			& (f_used < 6'(dmac_pkg::DFIFO_BEATS));
		// Reserved code 3 runs as 64 bytes; a zero burst would hang writes.
		assign burst_beats = tc_burst_reg[2*t+1] ? 4'h8
			: 4'h2 << tc_burst_reg[2*t];
		assign burst_len = (wr_left < 14'(burst_beats)) ? wr_left[3:0] : burst_beats;
		assign burst_start = (dcnt_reg != 3'h0) & (burst_left_reg == 4'h0)
			& (wr_left != 14'h0000) & (fcnt_reg >= 5'(burst_len));
		assign wr_issue = (burst_left_reg != 4'h0) & (fcnt_reg != 5'h00)
			& (~wr_q_reg.valid | wr_fire);
		assign retire = (dcnt_reg != 3'h0) & (wr_left == 14'h0000)
			& (~wr_q_reg.valid | wr_fire);
		assign tc_busy_prog[t] = prog_v_reg;
		assign tc_busy[t] = prog_v_reg | (dcnt_reg != 3'h0);
		assign rd_req[t] = rd_q_reg;
		assign wr_req[t] = wr_q_reg;
		assign cmp_v[t] = cmp_v_reg;
		assign cmp_code[t] = cmp_code_reg;
		assign cmp_ie[t] = cmp_ie_reg;
		assign cmp_ce[t] = cmp_ce_reg;

		// Program set, source active set and read commands.
		always_ff @(posedge clk) begin
			if (reset) begin
				prog_v_reg <= 1'b0;
				prog_tr_reg <= '0;
				rd_left_reg <= '0;
				rd_addr_reg <= '0;
				rd_q_reg <= '0;
				outst_reg <= '0;
			end else begin
				if (tr_push[t]) begin
					prog_v_reg <= 1'b1;
					prog_tr_reg <= sub_tr_reg;
				end else if (move) begin
					prog_v_reg <= 1'b0;
				end
				if (move) begin
					rd_left_reg <= prog_tr_reg.beats;
					rd_addr_reg <= prog_tr_reg.src;
				end else if (rd_issue) begin
					rd_left_reg <= rd_left_reg - 14'h0001;
					rd_addr_reg <= rd_addr_reg + 32'(dmac_pkg::BEAT_BYTES);
				end
				if (rd_issue)
					rd_q_reg <= '{valid: 1'b1, addr: rd_addr_reg};
				else if (rd_fire)
					rd_q_reg.valid <= 1'b0;
				outst_reg <= outst_reg + 5'(rd_fire) - 5'(rd_ret[t].valid);
			end
		end

		// Destination contexts, data FIFO and write commands.
		always_ff @(posedge clk) begin
			if (reset) begin
				dwp_reg <= '0;
				drp_reg <= '0;
				dcnt_reg <= '0;
				fwp_reg <= '0;
				frp_reg <= '0;
				fcnt_reg <= '0;
				wr_done_reg <= '0;
				burst_left_reg <= '0;
				wr_q_reg <= '0;
				cmp_v_reg <= 1'b0;
				cmp_code_reg <= '0;
				cmp_ie_reg <= 1'b0;
				cmp_ce_reg <= 1'b0;
			end else begin
				if (move) begin
					dctx[dwp_reg] <= prog_tr_reg;
					dwp_reg <= dwp_reg + 2'h1;
				end
				dcnt_reg <= dcnt_reg + 3'(move) - 3'(retire);
				if (rd_ret[t].valid) begin
					dmem[fwp_reg] <= rd_ret[t].data;
					fwp_reg <= fwp_reg + 4'h1;
				end
				fcnt_reg <= fcnt_reg + 5'(rd_ret[t].valid) - 5'(wr_issue);
				if (burst_start)
					burst_left_reg <= burst_len;
				else if (wr_issue)
					burst_left_reg <= burst_left_reg - 4'h1;
				if (wr_issue) begin
					wr_q_reg <= '{valid: 1'b1,
						addr: head.dst + {wr_done_reg[12:0], 3'b000},
						data: dmem[frp_reg]};
					frp_reg <= frp_reg + 4'h1;
					wr_done_reg <= wr_done_reg + 14'h0001;
				end else if (wr_fire) begin
					wr_q_reg.valid <= 1'b0;
				end
				if (retire) begin
					drp_reg <= drp_reg + 2'h1;
					wr_done_reg <= '0;
				end
				cmp_v_reg <= retire & ~head.early & (head.int_en | head.chain_en);
				cmp_code_reg <= head.tcc;
				cmp_ie_reg <= head.int_en;
				cmp_ce_reg <= head.chain_en;
			end
		end
	end

endmodule : dmac_top

// ### test/dmac_checker.sv
// Port-level checker for the DMA top, attached by bind.
// Assumes one clock and a synchronous active-high reset.
module dmac_checker (
	input wire logic                     clk, reset, psel, penable,
	input wire logic                     pready, pslverr, err_irq,
	input wire logic [12:0]              paddr,
	input wire logic [31:0]              prdata,
	input dmac_pkg::dmac_rd_req_t [1:0]  rd_req,
	input wire logic [1:0]               rd_ready, wr_ready,
	input dmac_pkg::dmac_rd_ret_t [1:0]  rd_ret,
	input dmac_pkg::dmac_wr_req_t [1:0]  wr_req,
	input wire logic [3:0]               comp_irq
);
	logic [5:0] outst, fill;
	// Reads in flight and beats buffered on controller zero.
	always_ff @(posedge clk) begin
		if (reset) begin
			outst <= '0;
			fill <= '0;
		end else begin
			outst <= outst + 6'(rd_req[0].valid && rd_ready[0]) - 6'(rd_ret[0].valid);
			fill <= fill + 6'(rd_ret[0].valid) - 6'(wr_req[0].valid && wr_ready[0]);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_setup(logic [12:0] a);
		psel && !penable && paddr == a;
	endsequence
	property p_rst;
		disable iff (1'b0) reset |=> !rd_req[0].valid && !wr_req[0].valid && comp_irq == 4'h0 && !err_irq;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs busy after reset");
	property p_rdhold;
		rd_req[0].valid && !rd_ready[0] |=> rd_req[0].valid && $stable(rd_req[0].addr);
	endproperty
	a_rdhold: assert property (p_rdhold) else $error("read command dropped");
	property p_wrhold;
		wr_req[0].valid && !wr_ready[0] |=> wr_req[0].valid && $stable(wr_req[0].data);
	endproperty
	a_wrhold: assert property (p_wrhold) else $error("write beat dropped");
	property p_room;
		outst + fill - 6'(wr_req[0].valid) <= 6'd16;
	endproperty
	a_room: assert property (p_room) else $error("data buffer overrun");
	property p_fill;
		wr_req[0].valid |-> fill != 6'd0;
	endproperty
	a_fill: assert property (p_fill) else $error("write without data");
	property p_ready;
		psel && !penable ##1 penable |-> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("access cycle not answered");
	property p_unmap;
		s_setup(13'h003C) ##1 penable |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("hole not refused");
	property p_map;
		s_setup(dmac_pkg::REG_Q_THRESH) ##1 penable |-> !pslverr;
	endproperty
	a_map: assert property (p_map) else $error("mapped register refused");
endmodule : dmac_checker

bind dmac_top dmac_checker chk_u (.clk, .reset, .psel, .penable, .pready,
	.pslverr, .err_irq, .paddr, .prdata, .rd_req, .rd_ready, .wr_ready,
	.rd_ret, .wr_req, .comp_irq);

// ### test/dmac_mem_model.sv
// Memory slave model for one controller's read and write ports.
// Assumes the bench's clock; read data is {addr, ~addr}.
module dmac_mem_model (
	input wire logic               clk, slow,
	input dmac_pkg::dmac_rd_req_t  rq,
	input dmac_pkg::dmac_wr_req_t  wq,
	output logic                   rdy, wrdy,
	output dmac_pkg::dmac_rd_ret_t rt,
	output logic [7:0]             wcnt,
	output dmac_pkg::dmac_wr_req_t lw
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] q[$];
	logic ph = 0;
	initial begin
		{rdy, wrdy, rt, wcnt, lw} = '0;
	end
	// Slow mode stalls both ports every other cycle; idle data keeps toggling.
	always @(posedge clk) begin
		ph <= ~ph;
		rdy <= slow ? ph : 1'b1;
		wrdy <= slow ? ~ph : 1'b1;
		if (rq.valid && rdy) q.push_back(rq.addr);
		if (wq.valid && wrdy) begin
			wcnt <= wcnt + 8'h1;
			lw <= wq;
		end
		if (q.size() > 0 && !(slow && ph)) begin
			rt <= {1'b1, q[0], ~q[0]};
			q.pop_front();
		end else rt <= {1'b0, ~rt.data};
	end
endmodule : dmac_mem_model

// ### test/dmac_tb_top.sv
// Self-checking bench for the DMA top over APB with two memory models.
// Assumes a 125 MHz clock and synchronous reset.
module dmac_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
	logic [12:0] paddr = '0;
	logic [31:0] pwdata = '0, evt_in = '0, prdata, rv;
	logic pready, pslverr, er, err_irq;
	logic [3:0] comp_irq;
	dmac_pkg::dmac_rd_req_t [1:0] rd_req;
	dmac_pkg::dmac_wr_req_t [1:0] wr_req;
	wire dmac_pkg::dmac_rd_ret_t [1:0] rd_ret;
	wire dmac_pkg::dmac_wr_req_t [1:0] lw;
	wire logic [1:0] rd_ready, wr_ready;
	wire logic [7:0] wcnt [2];
	int failures = 0, samples_checked = 0;
	always #4 clk = ~clk;
	dmac_top dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .evt_in, .rd_req, .rd_ready, .rd_ret,
		.wr_req, .wr_ready, .comp_irq, .err_irq);
	for (genvar t = 0; t < 2; t++) begin : g_mem
		dmac_mem_model mem_u (.clk, .slow, .rq(rd_req[t]), .wq(wr_req[t]),
			.rdy(rd_ready[t]), .wrdy(wr_ready[t]), .rt(rd_ret[t]),
			.wcnt(wcnt[t]), .lw(lw[t]));
	end
	task automatic print_verdict;
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input string n, input logic [63:0] s, e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// One APB transfer, entered just after a rising edge.
	task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb
	task automatic rc(input logic [12:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk($sformatf("reg %h", a), 64'(rv), 64'(e));
	endtask : rc
	task automatic pset(input int c, input logic [31:0] o, n);
		logic [12:0] b;
		b = 13'(32'h1000 + 32 * c);
		apb(1, b, o);
		apb(1, b + 13'h4, 32'h100);
		apb(1, b + 13'h8, n);
		apb(1, b + 13'hC, 32'h200 + 32'(c) * 32'h8);
		apb(1, b + 13'h1C, {31'h0, n != 0});
	endtask : pset
	// Reset, register defaults, then manual, pin and null-set triggers.
	initial begin
		repeat (12) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		rc(dmac_pkg::REG_Q_THRESH, 32'h00001010);
		rc(dmac_pkg::REG_Q_DEBUG, 32'h0);
		rc(13'h003C, 32'h0);
		chk("slverr", 64'(er), 64'h1);
		pset(1, 32'h00101000, 32'h00010010);
		apb(1, dmac_pkg::REG_INT_ENABLE, 32'h6);
		apb(1, dmac_pkg::REG_REGION, 32'h6);
		apb(1, dmac_pkg::REG_EVT_SET, 32'h2);
		repeat (300) if (comp_irq[0] !== 1'b1) @(posedge clk);
		rc(dmac_pkg::REG_INT_STATUS, 32'h2);
		chk("wcnt0", 64'(wcnt[0]), 64'h2);
		chk("addr0", 64'(lw[0].addr), 64'h210);
		chk("data0", lw[0].data, {32'h108, ~32'h108});
		apb(1, dmac_pkg::REG_INT_STATUS, 32'h2);
		pset(2, 32'h00102000, 32'h00010018);
		apb(1, dmac_pkg::REG_DMA_QMAP, 32'h4);
		apb(1, dmac_pkg::REG_EVT_ENABLE, 32'h4);
		slow <= 1;
		evt_in <= 32'h4;
		repeat (600) if (comp_irq[0] !== 1'b1) @(posedge clk);
		rc(dmac_pkg::REG_INT_STATUS, 32'h4);
		chk("wcnt1", 64'(wcnt[1]), 64'h3);
		chk("addr1", 64'(lw[1].addr), 64'h220);
		pset(3, 32'h0, 32'h0);
		apb(1, dmac_pkg::REG_EVT_SET, 32'h8);
		repeat (300) if (err_irq !== 1'b1) @(posedge clk);
		rc(dmac_pkg::REG_ERR_STATUS, 32'h4);
		chk("wcnt", 64'(wcnt[0] + wcnt[1]), 64'h5);
		print_verdict();
	end
	// Watchdog against a hang.
	initial begin
		#200000;
		failures++;
		print_verdict();
	end
endmodule : dmac_tb_top
